// >>> cce_regs.svh
// Constants of the clear-and-call execute block.
`ifndef CCE_REGS_SVH
`define CCE_REGS_SVH
`define CCE_INSN_W 14
`define CCE_PC_W 13
`define CCE_FILE_ADDR_W 7
`define CCE_LIT_W 11
`define CCE_DATA_W 8
`define CCE_WIPE_FILE_MASK 14'h3f80
`define CCE_WIPE_FILE_CODE 14'h0180
`define CCE_WIPE_ACC_CODE 14'h0103
`define CCE_CALL_MASK 14'h3800
`define CCE_CALL_CODE 14'h2000
`define CCE_LATCH_LO 3
`define CCE_LATCH_HI 4
`define CCE_CALL_CYCLES 2
`define CCE_ZERO_DATA 8'h00
`define CCE_PC_RST 13'h0000
`endif

// >>> cce_pkg.sv
// Types shared by the clear-and-call execute block.
package cce_pkg;
  typedef enum logic [2:0] {
    CCE_OP_NONE = 3'b001,
    CCE_OP_WIPE = 3'b010,
    CCE_OP_CALL = 3'b100
  } cce_op_e;
  typedef enum logic [1:0] {
    CCE_ST_EXEC = 2'b01,
    CCE_ST_FLUSH = 2'b10
  } cce_state_e;
endpackage

// >>> cce_dec_if.sv
// Decoded instruction bundle passed from the decoder to the executor.
`timescale 1ns/1ns
`default_nettype none
interface cce_dec_if;
  logic wipe_file;
  logic wipe_acc;
  logic call;
  logic [6:0] file_addr;
  logic [10:0] literal;
  modport dec (output wipe_file, output wipe_acc, output call, output file_addr, output literal);
  modport exe (input wipe_file, input wipe_acc, input call, input file_addr, input literal);
endinterface
`default_nettype wire

// >>> cce_decode.sv
// Opcode decoder for the two clear instructions and the call.
`timescale 1ns/1ns
`default_nettype none
`include "cce_regs.svh"
module cce_decode
  import cce_pkg::*;
(
  input wire logic [`CCE_INSN_W-1:0] insn_i,
  cce_dec_if.dec dec
);
  assign dec.wipe_file = (insn_i & `CCE_WIPE_FILE_MASK) == `CCE_WIPE_FILE_CODE;
  assign dec.wipe_acc = insn_i == `CCE_WIPE_ACC_CODE;
  assign dec.call = (insn_i & `CCE_CALL_MASK) == `CCE_CALL_CODE;
  assign dec.file_addr = insn_i[`CCE_FILE_ADDR_W-1:0];
  assign dec.literal = insn_i[`CCE_LIT_W-1:0];
endmodule
`default_nettype wire

// >>> cce_exec.sv
// Execute stage for file clear, accumulator clear and subroutine call.
`timescale 1ns/1ns
`default_nettype none
`include "cce_regs.svh"
// Operation
// - File-clear opcode writes zero to addressed file register and sets zero flag.
// - Accumulator-clear opcode loads zero into accumulator and sets zero flag.
// - Call pushes program counter plus one onto top of stack.
// - Call loads eleven-bit literal into program counter low bits.
// - Call copies latch bits four and three into counter bits twelve, eleven.
// - Call takes two instruction cycles.
module cce_exec
  import cce_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic insn_valid_i,
  input wire logic [`CCE_INSN_W-1:0] insn_i,
  input wire logic [`CCE_PC_W-1:0] program_counter_i,
  input wire logic [`CCE_DATA_W-1:0] upper_address_latch_i,
  output logic file_we_o,
  output logic [`CCE_FILE_ADDR_W-1:0] file_addr_o,
  output logic [`CCE_DATA_W-1:0] file_wdata_o,
  output logic acc_we_o,
  output logic [`CCE_DATA_W-1:0] acc_wdata_o,
  output logic zero_set_o,
  output logic push_o,
  output logic [`CCE_PC_W-1:0] top_of_stack_o,
  output logic pc_load_o,
  output logic [`CCE_PC_W-1:0] program_counter_o,
  output logic flush_o,
  output logic busy_o
);
  cce_dec_if dec_bus();
  cce_state_e state_r;
  cce_state_e state_nxt;
  cce_op_e op_kind;
  logic take;
  logic [1:0] lost_cnt_r;
  logic [`CCE_PC_W-1:0] return_pc;
  wire logic [`CCE_PC_W-1:0] target_pc;
  logic file_we_r;
  logic [`CCE_FILE_ADDR_W-1:0] file_addr_r;
  logic [`CCE_DATA_W-1:0] file_wdata_r;
  logic acc_we_r;
  logic [`CCE_DATA_W-1:0] acc_wdata_r;
  logic zero_set_r;
  logic push_r;
  logic [`CCE_PC_W-1:0] top_of_stack_r;
  logic pc_load_r;
  logic [`CCE_PC_W-1:0] program_counter_r;

  cce_decode u_decode (
    .insn_i(insn_i),
    .dec(dec_bus)
  );

  // A flushed slot holds the prefetched word, which must not execute.
  assign take = insn_valid_i && (state_r == CCE_ST_EXEC);
  assign busy_o = state_r == CCE_ST_FLUSH;

  // The three patterns are disjoint, so the order of the tests is immaterial.
  always_comb begin
    op_kind = CCE_OP_NONE;
    if (take && dec_bus.call) begin
      op_kind = CCE_OP_CALL;
    end else if (take && (dec_bus.wipe_file || dec_bus.wipe_acc)) begin
      op_kind = CCE_OP_WIPE;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lost_cnt_r <= 2'h0;
    end else if (op_kind == CCE_OP_CALL) begin
      lost_cnt_r <= 2'(`CCE_CALL_CYCLES - 1);
    end else if (lost_cnt_r != 2'h0) begin
      lost_cnt_r <= lost_cnt_r - 2'h1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CCE_ST_EXEC: begin
        if (op_kind == CCE_OP_CALL) begin
          state_nxt = CCE_ST_FLUSH;
        end
      end
      CCE_ST_FLUSH: begin
        if (lost_cnt_r <= 2'h1) begin
          state_nxt = CCE_ST_EXEC;
        end
      end
      default: begin
        state_nxt = CCE_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= CCE_ST_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      file_we_r <= 1'b0;
    end else begin
      file_we_r <= take && dec_bus.wipe_file;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      file_addr_r <= '0;
    end else if (take && dec_bus.wipe_file) begin
      file_addr_r <= dec_bus.file_addr;
    end
  end

  // File clear data.
  // The data never changes; a flop keeps every data output registered like the rest.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      file_wdata_r <= `CCE_ZERO_DATA;
    end else begin
      file_wdata_r <= `CCE_ZERO_DATA;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_we_r <= 1'b0;
    end else begin
      acc_we_r <= take && dec_bus.wipe_acc;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_wdata_r <= `CCE_ZERO_DATA;
    end else begin
      acc_wdata_r <= `CCE_ZERO_DATA;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zero_set_r <= 1'b0;
    end else begin
      zero_set_r <= op_kind == CCE_OP_WIPE;
    end
  end

  // Return address.
  // The carry out of the top bit is dropped, so the return address wraps round memory.
  assign return_pc = program_counter_i + `CCE_PC_W'(1);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      push_r <= 1'b0;
    end else begin
      push_r <= op_kind == CCE_OP_CALL;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      top_of_stack_r <= `CCE_PC_RST;
    end else if (op_kind == CCE_OP_CALL) begin
      top_of_stack_r <= return_pc;
    end
  end

  assign target_pc[`CCE_LIT_W-1:0] = dec_bus.literal;

  for (genvar g = 0; g <= `CCE_LATCH_HI - `CCE_LATCH_LO; g++) begin : g_upper
    assign target_pc[`CCE_LIT_W + g] = upper_address_latch_i[`CCE_LATCH_LO + g];
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_load_r <= 1'b0;
    end else begin
      pc_load_r <= op_kind == CCE_OP_CALL;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      program_counter_r <= `CCE_PC_RST;
    end else if (op_kind == CCE_OP_CALL) begin
      program_counter_r <= target_pc;
    end
  end

  // Outputs come straight from the flops.
  assign file_we_o = file_we_r;
  assign file_addr_o = file_addr_r;
  assign file_wdata_o = file_wdata_r;
  assign acc_we_o = acc_we_r;
  assign acc_wdata_o = acc_wdata_r;
  assign zero_set_o = zero_set_r;
  assign push_o = push_r;
  assign top_of_stack_o = top_of_stack_r;
  assign pc_load_o = pc_load_r;
  assign program_counter_o = program_counter_r;

  assign flush_o = busy_o;
endmodule
`default_nettype wire

// >>> cce_exec_asserts.sv
// Checker for the clear-and-call execute block.
`timescale 1ns/1ns
`default_nettype none
module cce_exec_asserts (
  input wire logic clock_i,
  rst_b_i,
  insn_valid_i,
  file_we_o,
  acc_we_o,
  zero_set_o,
  push_o,
  pc_load_o,
  busy_o,
  input wire logic [13:0] insn_i,
  input wire logic [12:0] program_counter_i,
  top_of_stack_o,
  program_counter_o,
  input wire logic [7:0] upper_address_latch_i,
  input wire logic [6:0] file_addr_o
);
  wire logic tk = insn_valid_i && !busy_o;
  wire logic cl = tk && insn_i[13:11] == 3'h4;
  wire logic wf = tk && insn_i[13:7] == 7'h03;
  wire logic wa = tk && insn_i == 14'h0103;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  AST_FILE: assert property (wf |=> file_we_o && zero_set_o
    && file_addr_o == $past(insn_i[6:0])) else $error("file clear");
  AST_ACC: assert property (wa |=> acc_we_o && zero_set_o) else $error("acc clear");
  AST_PUSH: assert property (cl |=> push_o
    && top_of_stack_o == $past(program_counter_i) + 13'h1) else $error("push");
  AST_LIT: assert property (cl |=> pc_load_o
    && program_counter_o[10:0] == $past(insn_i[10:0])) else $error("literal");
  AST_UP: assert property (cl |=>
    program_counter_o[12:11] == $past(upper_address_latch_i[4:3])) else $error("upper");
  AST_TWO: assert property (cl |=> busy_o ##1 !busy_o) else $error("call length");
  AST_ONE: assert property (wf || wa |=> !busy_o && !push_o && !pc_load_o)
    else $error("clear");
  cover property (cl ##2 cl);
  cover property (wf ##1 wa);
  cover property (busy_o && insn_valid_i);
endmodule
bind cce_exec cce_exec_asserts i_chk (
  .clock_i(clock_i),
  .rst_b_i(rst_b_i),
  .insn_valid_i(insn_valid_i),
  .file_we_o(file_we_o),
  .acc_we_o(acc_we_o),
  .zero_set_o(zero_set_o),
  .push_o(push_o),
  .pc_load_o(pc_load_o),
  .busy_o(busy_o),
  .insn_i(insn_i),
  .program_counter_i(program_counter_i),
  .top_of_stack_o(top_of_stack_o),
  .program_counter_o(program_counter_o),
  .upper_address_latch_i(upper_address_latch_i),
  .file_addr_o(file_addr_o)
);
`default_nettype wire

// >>> tb.sv
// Random bench for the clear-and-call execute block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock_i = 1'b0, rst_b_i = 1'b0, insn_valid_i = 1'b0;
  logic [13:0] insn_i = 14'h0;
  logic [12:0] program_counter_i = 13'h0, top_of_stack_o, program_counter_o, et, ep;
  logic [7:0] upper_address_latch_i = 8'h0, file_wdata_o, acc_wdata_o;
  logic [6:0] file_addr_o, ef, eu;
  logic file_we_o, acc_we_o, zero_set_o, push_o, pc_load_o, flush_o, busy_o;
  logic [31:0] r = 32'h5fb78bc0;
  int err_count = 0, comparisons = 0, cyc = 0;
  wire logic [6:0] pu = {file_we_o, acc_we_o, zero_set_o, push_o, pc_load_o, busy_o, flush_o};
  always #5 clock_i = ~clock_i;
  cce_exec i_dut (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .insn_valid_i(insn_valid_i),
    .insn_i(insn_i),
    .program_counter_i(program_counter_i),
    .upper_address_latch_i(upper_address_latch_i),
    .file_we_o(file_we_o),
    .file_addr_o(file_addr_o),
    .file_wdata_o(file_wdata_o),
    .acc_we_o(acc_we_o),
    .acc_wdata_o(acc_wdata_o),
    .zero_set_o(zero_set_o),
    .push_o(push_o),
    .top_of_stack_o(top_of_stack_o),
    .pc_load_o(pc_load_o),
    .program_counter_o(program_counter_o),
    .flush_o(flush_o),
    .busy_o(busy_o)
  );
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [6:0] pulses(logic [13:0] w, logic t);
    logic f, a, c;
    f = t && w[13:7] == 7'h03;
    a = t && w == 14'h0103;
    c = t && w[13:11] == 3'h4;
    return {f, a, f | a, c, c, c, c};
  endfunction
  task automatic chk_strobe(logic [6:0] got, logic [6:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic chk(logic [12:0] got, logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    {eu, ef, et, ep} = '0;
    repeat (20) @(negedge clock_i);
    rst_b_i = 1'b1;
    for (int i = 0; i < 1500; i++) begin
      @(negedge clock_i);
      chk_strobe(pu, eu);
      chk({6'h0, file_addr_o}, {6'h0, ef});
      chk({5'h0, file_wdata_o | acc_wdata_o}, 13'h0);
      chk(top_of_stack_o, et);
      chk(program_counter_o, ep);
      // Mid-run reset: every output falls back at once and the next word is taken.
      if (i == 800) begin
        rst_b_i = 1'b0;
        {eu, ef, et, ep} = '0;
        repeat (2) @(negedge clock_i);
        chk_strobe(pu, eu);
        chk({6'h0, file_addr_o}, {6'h0, ef});
        chk(top_of_stack_o, et);
        chk(program_counter_o, ep);
        rst_b_i = 1'b1;
      end
      r = xs(r);
      insn_valid_i = i < 8 || r[0] || r[1];
      program_counter_i = i < 4 ? 13'h1fff : r[12:0];
      upper_address_latch_i = r[20:13];
      case (r[31:30])
        2'h0: insn_i = {7'h03, r[27:21]};
        2'h1: insn_i = 14'h0103;
        2'h2: insn_i = {3'h4, r[29:19]};
        default: insn_i = r[27:14];
      endcase
      // Paired calls at both literal ends, the second dropped; then clears back to back.
      if (i < 4) insn_i = {3'h4, {11{i[1]}}};
      else if (i < 8) insn_i = i[0] ? 14'h0103 : {7'h03, {7{i[1]}}};
      eu = pulses(insn_i, insn_valid_i && !eu[1]);
      if (eu[6]) ef = insn_i[6:0];
      if (eu[3]) begin
        et = program_counter_i + 13'h1;
        ep = {upper_address_latch_i[4:3], insn_i[10:0]};
      end
    end
    wrap_up();
  end
endmodule
`default_nettype wire
